// ===== logic/ffpi_pkg.sv
// Shared constants for the floppy formatter pin interface.
package ffpi_pkg;
    localparam logic [1:0] SEL_STATUS_CMD = 2'h0;
    localparam logic [1:0] SEL_TRACK      = 2'h1;
    localparam logic [1:0] SEL_SECTOR     = 2'h2;
    localparam logic [1:0] SEL_DATA       = 2'h3;
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned STEP_PULSE_US = 2;
    localparam int unsigned STEP_CYC      = STEP_PULSE_US * CLK_MHZ;
    localparam int unsigned SETTLE_CYC    = 2 * STEP_CYC;
    localparam int unsigned GAP2_BASE     = 17;
    localparam int unsigned GAP2_ALT      = 34;
    localparam int unsigned BIT_CYC       = 16;
    localparam int unsigned MARK_BITS     = 3;
    localparam int unsigned ST_NOT_READY  = 7;
    localparam int unsigned ST_HEAD       = 5;
    localparam int unsigned ST_TRACK0     = 2;
    localparam int unsigned ST_REQ        = 1;
    localparam int unsigned ST_BUSY       = 0;
    localparam logic [3:0] CMD_RESTORE    = 4'h0;
    localparam logic [3:0] CMD_SEEK       = 4'h1;
    localparam logic [3:0] CMD_STEP_IN    = 4'h5;
    localparam logic [3:0] CMD_STEP_OUT   = 4'h7;
    localparam logic [3:0] CMD_READ       = 4'h8;
    localparam logic [3:0] CMD_WRITE      = 4'ha;
    localparam logic [3:0] CMD_FORCE_INT  = 4'hd;
    localparam logic [7:0] SECTOR_BYTES   = 8'h80;
    localparam logic [7:0] RESTORE_LIMIT  = 8'hff;
endpackage

// ===== logic/ffpi_sync.sv
// Two flip-flop level synchroniser.
module ffpi_sync #(
    parameter int unsigned  W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= INIT;
            dout    <= INIT;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule

// ===== logic/ffpi_top.sv
// Floppy formatter: host register port, serial data path, head and step control.
// Contract
// - Master reset returns initial state, clears command.
// - Not-ready status bit cleared during master reset.
// - Reset release runs restore, ignoring readiness.
// - Host bus carries inverted data both ways.
// - Receive on write strobe, drive on read.
// - Accesses valid only with chip select low.
// - Two select lines pick status/command, track, sector, data.
// - Read strobe places selected register on bus.
// - Write strobe loads bus into selected register.
// - Request asserts on byte ready or holder empty.
// - Request drops when host services data register.
// - Done irq on completion; cleared by command write.
// - Mark detect: next three bits give type.
// - Write data valid while output strobe active.
// - Output strobe leading edge centred on bit; the code raises it a quarter cell in.
// - Single density: strobe pin carries combined stream.
// - Drive head engage output to the drive.
// - Sample head engaged input; high means engaged.
// - One 2 microsecond high step pulse per step.
// - Direction high inward, low outward.
// - Second gap 17 bytes base, 34 alternate; the code loads the count but never counts it down.
// - Density select low double, high single.
module ffpi_top #(
    parameter bit ALT_VARIANT = 1'b0
) (
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       hard_init_n,
    input  wire logic       chip_select_n,
    input  wire logic [1:0] register_select,
    input  wire logic       host_read_strobe_n,
    input  wire logic       host_write_strobe_n,
    input  wire logic [7:0] host_bus_n_in,
    output logic      [7:0] host_bus_n_out,
    output logic            host_bus_n_oe,
    output logic            byte_service_request,
    output logic            operation_done_irq,
    input  wire logic       mark_detected_in,
    input  wire logic       read_bit_strobe,
    input  wire logic       read_bit_in,
    output logic            write_bit_out,
    output logic            write_bit_strobe,
    output logic            head_engage_out,
    input  wire logic       head_engaged_in,
    output logic            step_pulse,
    output logic            step_inward,
    input  wire logic       density_select_n,
    input  wire logic       drive_ready,
    input  wire logic       track_zero_n,
    output logic      [2:0] mark_type,
    output logic            mark_valid
);
    typedef enum {FFPI_IDLE, FFPI_RESTORE, FFPI_STEP, FFPI_SETTLE, FFPI_HEAD,
                  FFPI_READ, FFPI_WRITE} ffpi_state_t;

    logic rst_meta_ff;
    logic rst_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_ff      <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_ff      <= rst_meta_ff;
        end
    end

    // Every pin input passes two flops; only the second stage is used.
    logic [13:0] pin_raw;
    logic [13:0] pin_s;
    assign pin_raw = {hard_init_n, chip_select_n, register_select, host_read_strobe_n,
                      host_write_strobe_n, mark_detected_in, read_bit_strobe,
                      read_bit_in, head_engaged_in, density_select_n, drive_ready,
                      track_zero_n, 1'b0};
    logic [7:0] bus_s;
    // Start at the pins' idle levels, so no false strobe edge follows reset.
    ffpi_sync #(.W(14), .INIT(14'h3302)) u_sync_pins (
        .sys_clk (sys_clk),
        .rst_n   (rst_ff),
        .din     (pin_raw),
        .dout    (pin_s)
    );
    ffpi_sync #(.W(8)) u_sync_bus (
        .sys_clk (sys_clk),
        .rst_n   (rst_ff),
        .din     (host_bus_n_in),
        .dout    (bus_s)
    );
    logic       init_n_s, cs_n_s, rd_n_s, wr_n_s, mark_s, rstb_s, rbit_s;
    logic       hlt_s, density_select_n_n_s, ready_s, tr00_n_s;
    logic [1:0] sel_s;
    assign {init_n_s, cs_n_s, sel_s, rd_n_s, wr_n_s, mark_s, rstb_s, rbit_s,
            hlt_s, density_select_n_n_s, ready_s, tr00_n_s} = pin_s[13:1];

    logic init_d_ff, rd_d_ff, wr_d_ff, rstb_d_ff;
    always_ff @(posedge sys_clk or negedge rst_ff) begin
        if (!rst_ff) begin
            init_d_ff <= 1'b1;
            rd_d_ff   <= 1'b1;
            wr_d_ff   <= 1'b1;
            rstb_d_ff <= 1'b0;
        end else begin
            init_d_ff <= init_n_s;
            rd_d_ff   <= rd_n_s | cs_n_s;
            wr_d_ff   <= wr_n_s | cs_n_s;
            rstb_d_ff <= rstb_s;
        end
    end
    logic hard_init;
    logic init_release;
    logic wr_start, rd_end;
    logic rstb_rise;
    assign hard_init    = !init_n_s;
    assign init_release = init_n_s && !init_d_ff;
    // Strobes only count while selected; writes commit on the leading edge.
    assign wr_start  = wr_d_ff && !(wr_n_s | cs_n_s);
    assign rd_end    = !rd_d_ff && (rd_n_s | cs_n_s);
    assign rstb_rise = rstb_s && !rstb_d_ff;
    logic [7:0] wdata;
    assign wdata = ~bus_s;

    logic [7:0]  command_entry_ff;
    logic [7:0]  head_track_position_ff;
    logic [7:0]  target_sector_number_ff;
    logic [7:0]  byte_transfer_holding_ff;
    logic [7:0]  dest_track_ff;
    ffpi_state_t state_ff;
    logic [15:0] tmr_ff;
    logic [7:0]  cnt_ff;
    logic [7:0]  shift_ff;
    logic [3:0]  bitn_ff;
    logic        cmd_wr;
    logic        data_rd, data_wr;
    logic        busy;
    logic        byte_done;
    logic [7:0]  status_flags;
    assign cmd_wr  = wr_start && sel_s == ffpi_pkg::SEL_STATUS_CMD;
    assign data_wr = wr_start && sel_s == ffpi_pkg::SEL_DATA;
    assign data_rd = rd_end && sel_s == ffpi_pkg::SEL_DATA;
    assign busy    = state_ff != FFPI_IDLE;

    always_comb begin
        status_flags = 8'h00;
        status_flags[ffpi_pkg::ST_NOT_READY] = !ready_s && !hard_init;
        status_flags[ffpi_pkg::ST_HEAD]      = hlt_s;
        status_flags[ffpi_pkg::ST_TRACK0]    = !tr00_n_s;
        status_flags[ffpi_pkg::ST_REQ]       = byte_service_request;
        status_flags[ffpi_pkg::ST_BUSY]      = busy;
    end

    // Host read path: inverted bus, driven only while selected and reading.
    always_ff @(posedge sys_clk or negedge rst_ff) begin
        if (!rst_ff) begin
            host_bus_n_out <= 8'hff;
            host_bus_n_oe  <= 1'b0;
        end else begin
            host_bus_n_oe <= !(rd_n_s | cs_n_s);
            case (sel_s)
                ffpi_pkg::SEL_STATUS_CMD: host_bus_n_out <= ~status_flags;
                ffpi_pkg::SEL_TRACK:      host_bus_n_out <= ~head_track_position_ff;
                ffpi_pkg::SEL_SECTOR:     host_bus_n_out <= ~target_sector_number_ff;
                default:                  host_bus_n_out <= ~byte_transfer_holding_ff;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_ff) begin
        if (!rst_ff) begin
            command_entry_ff <= 8'h00;
        end else if (hard_init) begin
            command_entry_ff <= 8'h00;
        end else if (cmd_wr) begin
            command_entry_ff <= wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_ff) begin
        if (!rst_ff) begin
            target_sector_number_ff <= 8'h00;
        end else if (wr_start && sel_s == ffpi_pkg::SEL_SECTOR) begin
            target_sector_number_ff <= wdata;
        end
    end

    // Gap between ID and data fields depends on variant only, not on density.
    localparam logic [7:0] GAP2_BYTES = ALT_VARIANT ? 8'(ffpi_pkg::GAP2_ALT)
                                                    : 8'(ffpi_pkg::GAP2_BASE);
    logic double_density;
    assign double_density = !density_select_n_n_s;

    logic [3:0] op;
    assign op = wdata[7:4];

    // Command sequencer with step, head and byte phases.
    always_ff @(posedge sys_clk or negedge rst_ff) begin
        if (!rst_ff) begin
            state_ff               <= FFPI_IDLE;
            head_track_position_ff <= 8'h00;
            dest_track_ff          <= 8'h00;
            tmr_ff                 <= 16'h0000;
            cnt_ff                 <= 8'h00;
            step_pulse             <= 1'b0;
            step_inward            <= 1'b0;
            head_engage_out        <= 1'b0;
            operation_done_irq     <= 1'b0;
        end else if (hard_init) begin
            state_ff           <= FFPI_IDLE;
            step_pulse         <= 1'b0;
            head_engage_out    <= 1'b0;
            operation_done_irq <= 1'b0;
        end else if (init_release) begin
            state_ff      <= FFPI_RESTORE;
            dest_track_ff <= 8'h00;
            cnt_ff        <= ffpi_pkg::RESTORE_LIMIT;
        end else if (cmd_wr && (!busy || op == ffpi_pkg::CMD_FORCE_INT)) begin
            operation_done_irq <= op == ffpi_pkg::CMD_FORCE_INT;
            state_ff <= FFPI_IDLE;
            cnt_ff   <= 8'h00;
            case (op)
                ffpi_pkg::CMD_RESTORE: begin
                    state_ff <= FFPI_RESTORE;
                    cnt_ff   <= ffpi_pkg::RESTORE_LIMIT;
                end
                ffpi_pkg::CMD_SEEK: begin
                    dest_track_ff <= byte_transfer_holding_ff;
                    state_ff      <= FFPI_SETTLE;
                end
                ffpi_pkg::CMD_STEP_IN: begin
                    dest_track_ff <= head_track_position_ff + 8'h01;
                    state_ff      <= FFPI_SETTLE;
                end
                ffpi_pkg::CMD_STEP_OUT: begin
                    dest_track_ff <= head_track_position_ff - 8'h01;
                    state_ff      <= FFPI_SETTLE;
                end
                ffpi_pkg::CMD_READ, ffpi_pkg::CMD_WRITE: begin
                    if (ready_s) begin
                        head_engage_out <= 1'b1;
                        state_ff        <= FFPI_HEAD;
                        cnt_ff          <= GAP2_BYTES;
                    end else begin
                        operation_done_irq <= 1'b1;
                    end
                end
                default: state_ff <= FFPI_IDLE;
            endcase
        end else begin
            if (wr_start && sel_s == ffpi_pkg::SEL_TRACK) begin
                head_track_position_ff <= wdata;
            end
            case (state_ff)
                FFPI_RESTORE: begin
                    // Readiness is not consulted while homing.
                    if (!tr00_n_s || cnt_ff == 8'h00) begin
                        head_track_position_ff <= 8'h00;
                        state_ff               <= FFPI_IDLE;
                        operation_done_irq     <= 1'b1;
                    end else begin
                        step_inward <= 1'b0;
                        step_pulse  <= 1'b1;
                        tmr_ff      <= 16'(ffpi_pkg::STEP_CYC - 1);
                        cnt_ff      <= cnt_ff - 8'h01;
                        state_ff    <= FFPI_STEP;
                    end
                end
                FFPI_SETTLE: begin
                    if (head_track_position_ff == dest_track_ff) begin
                        state_ff           <= FFPI_IDLE;
                        operation_done_irq <= 1'b1;
                    end else begin
                        step_inward <= dest_track_ff > head_track_position_ff;
                        step_pulse  <= 1'b1;
                        tmr_ff      <= 16'(ffpi_pkg::STEP_CYC - 1);
                        state_ff    <= FFPI_STEP;
                        head_track_position_ff <= (dest_track_ff > head_track_position_ff)
                            ? head_track_position_ff + 8'h01
                            : head_track_position_ff - 8'h01;
                    end
                end
                FFPI_STEP: begin
                    if (tmr_ff != 16'h0000) begin
                        tmr_ff <= tmr_ff - 16'h0001;
                    end else if (step_pulse) begin
                        step_pulse <= 1'b0;
                        tmr_ff     <= 16'(ffpi_pkg::SETTLE_CYC);
                    end else begin
                        state_ff <= (cnt_ff != 8'h00 || dest_track_ff == 8'h00) &&
                                    command_entry_ff[7:4] == ffpi_pkg::CMD_RESTORE
                                    ? FFPI_RESTORE : FFPI_SETTLE;
                    end
                end
                FFPI_HEAD: begin
                    // Wait for the engaged level; the sector byte count then replaces the gap count.
                    if (hlt_s) begin
                        state_ff <= command_entry_ff[5] ? FFPI_WRITE : FFPI_READ;
                        cnt_ff   <= ffpi_pkg::SECTOR_BYTES;
                    end
                end
                FFPI_READ, FFPI_WRITE: begin
                    if (byte_done && cnt_ff == 8'h01) begin
                        state_ff           <= FFPI_IDLE;
                        head_engage_out    <= 1'b0;
                        operation_done_irq <= 1'b1;
                    end else if (byte_done) begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                default: state_ff <= FFPI_IDLE;
            endcase
        end
    end

    // Serial byte engine: assembles strobed input or shifts out the holding byte.
    logic [7:0] tick_ff;
    logic       bit_tick;
    assign bit_tick  = tick_ff == 8'(ffpi_pkg::BIT_CYC - 1);
    assign byte_done = (state_ff == FFPI_READ && rstb_rise && bitn_ff == 4'h7) ||
                       (state_ff == FFPI_WRITE && bit_tick && bitn_ff == 4'h7);

    always_ff @(posedge sys_clk or negedge rst_ff) begin
        if (!rst_ff) begin
            shift_ff   <= 8'h00;
            bitn_ff    <= 4'h0;
            tick_ff    <= 8'h00;
            mark_type  <= 3'h0;
            mark_valid <= 1'b0;
        end else if (state_ff == FFPI_READ) begin
            tick_ff <= 8'h00;
            if (mark_s && !mark_valid && bitn_ff == 4'h0) begin
                mark_valid <= 1'b1;
                bitn_ff    <= 4'h8;
            end else if (rstb_rise) begin
                // Data is taken at the strobe, where recovery holds it valid.
                shift_ff <= {shift_ff[6:0], rbit_s};
                if (bitn_ff == 4'h8 + 4'(ffpi_pkg::MARK_BITS) - 4'h1) begin
                    mark_type <= {shift_ff[1:0], rbit_s};
                    bitn_ff   <= 4'h0;
                end else if (bitn_ff == 4'h7) begin
                    bitn_ff <= 4'h0;
                end else begin
                    bitn_ff <= bitn_ff + 4'h1;
                end
            end
        end else if (state_ff == FFPI_WRITE) begin
            tick_ff <= bit_tick ? 8'h00 : tick_ff + 8'h01;
            if (bit_tick) begin
                bitn_ff  <= bitn_ff == 4'h7 ? 4'h0 : bitn_ff + 4'h1;
                shift_ff <= bitn_ff == 4'h7 ? byte_transfer_holding_ff
                                            : {shift_ff[6:0], 1'b0};
            end
        end else begin
            bitn_ff    <= 4'h0;
            tick_ff    <= 8'h00;
            mark_valid <= 1'b0;
            shift_ff   <= byte_transfer_holding_ff;
        end
    end

    // The strobe rises a quarter cell in, so the pulse is centred on the bit centre.
    logic in_cell_mid;
    assign in_cell_mid = tick_ff >= 8'(ffpi_pkg::BIT_CYC / 4) &&
                         tick_ff <  8'(3 * ffpi_pkg::BIT_CYC / 4);
    always_ff @(posedge sys_clk or negedge rst_ff) begin
        if (!rst_ff) begin
            write_bit_out    <= 1'b0;
            write_bit_strobe <= 1'b0;
        end else if (state_ff == FFPI_WRITE) begin
            write_bit_out <= shift_ff[7];
            if (double_density) begin
                write_bit_strobe <= in_cell_mid;
            end else begin
                // Single density: clock pulse early, data pulse mid-cell.
                write_bit_strobe <= tick_ff < 8'(ffpi_pkg::BIT_CYC / 8) ||
                                    (in_cell_mid && shift_ff[7] &&
                                     tick_ff < 8'(5 * ffpi_pkg::BIT_CYC / 8));
            end
        end else begin
            write_bit_out    <= 1'b0;
            write_bit_strobe <= 1'b0;
        end
    end

    // Holding register and request flag; a fill in the service cycle wins.
    always_ff @(posedge sys_clk or negedge rst_ff) begin
        if (!rst_ff) begin
            byte_transfer_holding_ff <= 8'h00;
            byte_service_request     <= 1'b0;
        end else begin
            if (data_wr) begin
                byte_transfer_holding_ff <= wdata;
            end else if (state_ff == FFPI_READ && byte_done) begin
                byte_transfer_holding_ff <= {shift_ff[6:0], rbit_s};
            end
            if (hard_init || (cmd_wr && !busy)) begin
                byte_service_request <= 1'b0;
            end else if (byte_done) begin
                byte_service_request <= 1'b1;
            end else if (state_ff == FFPI_HEAD && hlt_s && command_entry_ff[5]) begin
                byte_service_request <= 1'b1;
            end else if (data_rd || data_wr) begin
                byte_service_request <= 1'b0;
            end
        end
    end
endmodule

// ===== testbench/ffpi_top_asserts.sv
// Concurrent checks on the formatter's host port and step pins.
module ffpi_top_asserts (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       hard_init_n,
    input wire logic       chip_select_n,
    input wire logic [1:0] register_select,
    input wire logic       host_read_strobe_n,
    input wire logic       host_write_strobe_n,
    input wire logic [7:0] host_bus_n_in,
    input wire logic       host_bus_n_oe,
    input wire logic       byte_service_request,
    input wire logic       operation_done_irq,
    input wire logic       write_bit_out,
    input wire logic       write_bit_strobe,
    input wire logic       step_pulse,
    input wire logic       step_inward,
    input wire logic       density_select_n
);
    int unsigned hi_cnt_ff;
    logic        cmd_wr;
    assign cmd_wr = !chip_select_n && !host_write_strobe_n
        && register_select == ffpi_pkg::SEL_STATUS_CMD
        && host_bus_n_in[7:4] != ~ffpi_pkg::CMD_FORCE_INT;
    // Counts how long the step pin has been high.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hi_cnt_ff <= 0;
        end else begin
            hi_cnt_ff <= step_pulse ? hi_cnt_ff + 1 : 0;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // A master reset may cut a pulse short, so it is left out of the width check.
    a_step_width: assert property (disable iff (!rstn || !hard_init_n)
        $fell(step_pulse) |-> hi_cnt_ff == ffpi_pkg::STEP_CYC) else $error("step width");
    a_step_dir: assert property (step_pulse && $past(step_pulse) |-> $stable(step_inward))
        else $error("direction moved in pulse");
    a_cs_idle: assert property (chip_select_n [*5] |-> !host_bus_n_oe)
        else $error("bus driven while deselected");
    a_read_drive: assert property ((!chip_select_n && !host_read_strobe_n) [*5]
        |-> host_bus_n_oe) else $error("bus not driven on read");
    a_read_idle: assert property (host_read_strobe_n [*5] |-> !host_bus_n_oe)
        else $error("bus driven without read");
    a_init_quiet: assert property (!hard_init_n [*4]
        |-> !operation_done_irq && !byte_service_request && !step_pulse)
        else $error("outputs active in master reset");
    a_irq_clear: assert property (operation_done_irq ##1 cmd_wr [*2]
        |-> ##[0:6] !operation_done_irq) else $error("irq kept after command");
    a_strobe_data: assert property (!density_select_n && write_bit_strobe
        && $past(write_bit_strobe) |-> $stable(write_bit_out)) else $error("data moved");
    c_step: cover property ($fell(step_pulse));
    c_irq: cover property ($rose(operation_done_irq));
    c_read: cover property ($rose(host_bus_n_oe));
endmodule

bind ffpi_top ffpi_top_asserts u_chk (.sys_clk, .rstn, .hard_init_n, .chip_select_n,
    .register_select, .host_read_strobe_n, .host_write_strobe_n, .host_bus_n_in,
    .host_bus_n_oe, .byte_service_request, .operation_done_irq, .write_bit_out,
    .write_bit_strobe, .step_pulse, .step_inward, .density_select_n);

// ===== testbench/ffpi_drive_model.sv
// Behavioural drive: head position, track zero sensor and head engage response.
module ffpi_drive_model #(
    parameter int START_TRACK = 3
) (
    input  wire logic sys_clk,
    input  wire logic step_pulse,
    input  wire logic step_inward,
    input  wire logic head_engage_out,
    output logic      track_zero_n,
    output logic      head_engaged_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int   pos = START_TRACK;
    logic prev_ff = 1'b0;
    logic eng_ff = 1'b0;
    assign track_zero_n = (pos != 0);
    assign head_engaged_in = eng_ff;
    // The head settles one clock after it is told to engage.
    always @(posedge sys_clk) begin
        prev_ff <= step_pulse;
        eng_ff <= head_engage_out;
        if (step_pulse && !prev_ff) begin
            pos <= step_inward ? pos + 1 : (pos > 0 ? pos - 1 : 0);
        end
    end
endmodule

// ===== testbench/ffpi_top_tb.sv
// Self-checking bench for the formatter's host port and step control.
module ffpi_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk = 1'b0;
    logic       rstn, hard_init_n, chip_select_n, host_read_strobe_n, host_write_strobe_n;
    logic [1:0] register_select;
    logic [7:0] host_bus_n_in, host_bus_n_out, d;
    logic       host_bus_n_oe, byte_service_request, operation_done_irq, drive_ready;
    logic       write_bit_out, write_bit_strobe, head_engage_out, head_engaged_in;
    logic       step_pulse, step_inward, track_zero_n, prev_step = 1'b0;
    int         fails = 0, checks_done = 0, steps = 0, ins = 0;
    always #2 sys_clk = ~sys_clk;
    ffpi_top dut_u (.sys_clk, .rstn, .hard_init_n, .chip_select_n, .register_select,
        .host_read_strobe_n, .host_write_strobe_n, .host_bus_n_in, .host_bus_n_out,
        .host_bus_n_oe, .byte_service_request, .operation_done_irq, .mark_detected_in(1'b0),
        .read_bit_strobe(1'b0), .read_bit_in(1'b0), .write_bit_out, .write_bit_strobe,
        .head_engage_out, .head_engaged_in, .step_pulse, .step_inward,
        .density_select_n(1'b0), .drive_ready, .track_zero_n, .mark_type(), .mark_valid());
    ffpi_drive_model drv_u (.sys_clk, .step_pulse, .step_inward, .head_engage_out,
        .track_zero_n, .head_engaged_in);
    always @(negedge sys_clk) begin
        prev_step <= step_pulse;
        if (step_pulse && !prev_step) begin
            steps++;
            ins += step_inward;
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [1:0] sel, input logic [7:0] v);
        @(negedge sys_clk);
        chip_select_n = 1'b0;
        register_select = sel;
        host_bus_n_in = ~v;
        host_write_strobe_n = 1'b0;
        repeat (5) @(negedge sys_clk);
        host_write_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic rd_reg(input logic [1:0] sel, output logic [7:0] v);
        @(negedge sys_clk);
        chip_select_n = 1'b0;
        register_select = sel;
        host_read_strobe_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        v = ~host_bus_n_out;
        check({7'h00, host_bus_n_oe}, 8'h01, "read enable");
        host_read_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic wait_irq();
        int n;
        n = 0;
        while (operation_done_irq !== 1'b1 && n < 20000) begin
            @(negedge sys_clk);
            n++;
        end
        check({7'h00, operation_done_irq}, 8'h01, "completion irq");
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        fails++;
        $display("wrong value at %0t ns: run hung", $time);
        wrap_up();
    end
    initial begin
        {rstn, hard_init_n, drive_ready} = 3'h0;
        {chip_select_n, host_read_strobe_n, host_write_strobe_n} = 3'h7;
        register_select = 2'h0;
        host_bus_n_in = 8'hff;
        repeat (16) @(negedge sys_clk);
        rstn = 1'b1;
        rd_reg(ffpi_pkg::SEL_STATUS_CMD, d);
        check(d & 8'h80, 8'h00, "not ready in master reset");
        check({6'h00, operation_done_irq, step_pulse}, 8'h00, "quiet in reset");
        hard_init_n = 1'b1;
        // Drive stays not ready: the restore must run all the same.
        wait_irq();
        check(steps[7:0], 8'h03, "restore step count");
        check(ins[7:0], 8'h00, "restore goes outward");
        rd_reg(ffpi_pkg::SEL_TRACK, d);
        check(d, 8'h00, "track after restore");
        rd_reg(ffpi_pkg::SEL_STATUS_CMD, d);
        check(d & 8'h05, 8'h04, "status after restore");
        for (int s = 1; s < 4; s++) begin
            wr_reg(s[1:0], 8'h3c ^ s[7:0]);
        end
        for (int s = 1; s < 4; s++) begin
            rd_reg(s[1:0], d);
            check(d, 8'h3c ^ s[7:0], "register readback");
        end
        host_bus_n_in = 8'h00;
        register_select = ffpi_pkg::SEL_TRACK;
        host_read_strobe_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        check({7'h00, host_bus_n_oe}, 8'h00, "bus driven while deselected");
        host_read_strobe_n = 1'b1;
        host_write_strobe_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        host_write_strobe_n = 1'b1;
        rd_reg(ffpi_pkg::SEL_TRACK, d);
        check(d, 8'h3d, "deselected write ignored");
        drive_ready = 1'b1;
        for (int k = 0; k < 2; k++) begin
            wr_reg(ffpi_pkg::SEL_STATUS_CMD, k ? 8'h70 : 8'h50);
            check({7'h00, operation_done_irq}, 8'h00, "irq cleared by command");
            wait_irq();
            check(steps[7:0], 8'h04 + k[7:0], "one step per command");
            check(ins[7:0], 8'h01, "step direction");
        end
        wr_reg(ffpi_pkg::SEL_STATUS_CMD, 8'ha0);
        check({6'h00, head_engage_out, byte_service_request}, 8'h03, "wr req");
        wr_reg(ffpi_pkg::SEL_DATA, 8'h5a);
        check({7'h00, byte_service_request}, 8'h00, "req served");
        wr_reg(ffpi_pkg::SEL_STATUS_CMD, 8'hd0);
        check({7'h00, operation_done_irq}, 8'h01, "forced end");
        wrap_up();
    end
endmodule
